// ### ecg_counter.sv
/*
  ecg_counter: pair of 8-bit event counters, chained for 16-bit mode.
  assumes count pulses are one clock wide and already gated.
*/
`timescale 1ns/1ps
module ecg_counter (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       inc_low,   // gated pulse, low counter
  input  wire logic       inc_high,  // gated pulse, high counter
  input  wire logic       mode_8bit, // separate counters
  input  wire logic       cue_high,  // count_up_enable_high
  input  wire logic       cue_low,   // count_up_enable_low
  input  wire logic       crc_high,  // clear_release_high
  output logic [7:0]      cnt_high,  // event_count_high
  output logic [7:0]      cnt_low,   // event_count_low
  output logic            wrap_high, // one-cycle wrap pulse
  output logic            wrap_low   // one-cycle wrap pulse, 8-bit mode only
);
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       wh;
    logic       wl;
  } ecg_cnt_reg_t;

  ecg_cnt_reg_t cur;
  ecg_cnt_reg_t next_cur;
  logic         step_low;
  logic         step_high;

  assign cnt_high  = cur.hi;
  assign cnt_low   = cur.lo;
  assign wrap_high = cur.wh;
  assign wrap_low  = cur.wl;

  // increment and carry
  always_comb begin
    next_cur  = cur;
    step_low  = inc_low & cue_low;
    // 16-bit: high steps on low carry, needs cue_high set first
    step_high = mode_8bit ? (inc_high & cue_high) : (step_low & (cur.lo == 8'hFF) & cue_high);
    next_cur.wl = step_low & (cur.lo == 8'hFF) & mode_8bit;
    next_cur.wh = step_high & (cur.hi == 8'hFF);
    if (step_low) begin
      next_cur.lo = cur.lo + 8'h01;
    end
    if (!crc_high) begin
      // held in reset until clear released
      next_cur.hi = 8'h00;
      next_cur.wh = 1'b0;
    end else if (step_high) begin
      next_cur.hi = cur.hi + 8'h01;
    end
    if (!cue_low && !mode_8bit) begin
      next_cur.wl = 1'b0;
    end
  end

  // counter register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule

// ### ecg_gate_model.sv
/*
  ecg_gate_model: far side of the gate pin and the cpu interrupt input.
  assumes the bench calls drive from its main sequence only.
*/
`timescale 1ns/1ps
module ecg_gate_model (
  input  wire logic clk,
  input  wire logic irq,
  output logic      ext_gate_input
);
  int   irq_rises;  // requests taken by the cpu side
  logic irq_q;      // last sampled irq
  // pin starts closed so nothing counts before setup
  initial begin
    ext_gate_input = 1'b0;
    irq_rises = 0;
    irq_q = 1'b0;
  end
  // pin moves just after an edge, never on it
  task automatic drive(input logic lvl);
    @(posedge clk);
    ext_gate_input <= lvl;
  endtask
  // cpu side counts each new request
  always @(posedge clk) begin
    if (irq === 1'b1 && irq_q !== 1'b1) irq_rises++;
    irq_q <= irq;
  end
endmodule

// ### ecg_pkg.sv
/*
  ecg_pkg: constants for the event counter gate control block.
  assumes a single 10 MHz clock and a plain strobe register port.
*/
package ecg_pkg;
  // register byte offsets (one byte wide register port)
  localparam logic [3:0] ADDR_EDGE_SEL   = 4'h0;  // edge_select_reg
  localparam logic [3:0] ADDR_CTRL_STAT  = 4'h1;  // counter_ctrl_status
  localparam logic [3:0] ADDR_CMP_UPPER  = 4'h2;  // pwm_compare_upper
  localparam logic [3:0] ADDR_CMP_LOWER  = 4'h3;  // pwm_compare_lower
  localparam logic [3:0] ADDR_DAT_UPPER  = 4'h4;  // pwm_data_upper
  localparam logic [3:0] ADDR_DAT_LOWER  = 4'h5;  // pwm_data_lower
  localparam logic [3:0] ADDR_IRQ_FLAG   = 4'h6;  // irq_flag_reg_one
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h7;  // irq_enable_reg_one
  localparam logic [3:0] ADDR_CNT_HIGH   = 4'h8;  // event_count_high
  localparam logic [3:0] ADDR_CNT_LOW    = 4'h9;  // event_count_low
  localparam logic [3:0] ADDR_MODE       = 4'hA;  // power mode select
  // edge_select_reg fields
  localparam int EDGE_SEL_LO_BIT   = 0;  // gate_edge_sel_lo
  localparam int EDGE_SEL_HI_BIT   = 1;  // gate_edge_sel_hi
  localparam int PWM_ENABLE_BIT    = 2;  // pwm_gate_enable
  localparam int PWM_CLK_SEL_LSB   = 4;  // prescale select, 3 bits
  // counter_ctrl_status fields
  localparam int CUE_LOW_BIT       = 0;  // count_up_enable_low
  localparam int CUE_HIGH_BIT      = 1;  // count_up_enable_high
  localparam int CRC_HIGH_BIT      = 2;  // clear_release_high
  localparam int MODE_8BIT_BIT     = 3;  // two 8-bit counters when set
  localparam int ASYNC_SRC_BIT     = 4;  // event source is external
  localparam int OVF_LOW_BIT       = 6;  // low overflow flag
  localparam int OVF_HIGH_BIT      = 7;  // high overflow flag
  // flag and enable registers: gate irq in bit 0
  localparam int GATE_IRQ_BIT      = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // edge choices
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  // prescaled pwm clock: phi/2 .. phi/64
  localparam logic [5:0] PRESCALE_TOP = 6'h3F;
  // interrupt vector shared by both gate sources
  localparam int          GATE_IRQ_VECTOR = 6;
  localparam logic [15:0] GATE_VEC_ADDR_HI = 16'h000C;
  localparam logic [15:0] GATE_VEC_ADDR_LO = 16'h000D;
  // power modes
  typedef enum logic [2:0] {
    ECG_ACTIVE   = 3'h0,
    ECG_SLEEP    = 3'h1,
    ECG_WATCH    = 3'h2,
    ECG_SUBACT   = 3'h3,
    ECG_SUBSLEEP = 3'h4,
    ECG_STANDBY  = 3'h5,
    ECG_MODSTBY  = 3'h6
  } ecg_mode_t;
  // pwm phase, gray order low -> high
  typedef enum logic [1:0] {
    ECG_PWM_IDLE = 2'b00,
    ECG_PWM_LOW  = 2'b01,
    ECG_PWM_HIGH = 2'b11
  } ecg_pwm_state_t;
  // edge detect decode shared by both gate sources
  function automatic logic ecg_edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
    case (sel)
      EDGE_RISE: ecg_edge_hit = ~prev & cur;
      EDGE_FALL: ecg_edge_hit = prev & ~cur;
      default:   ecg_edge_hit = prev ^ cur;
    endcase
  endfunction
endpackage

// ### ecg_pwm.sv
/*
  ecg_pwm: pwm gate waveform, low for data+1 ticks then high to compare+1.
  assumes data < compare is kept by software while enabled.
*/
`timescale 1ns/1ps
module ecg_pwm (
  input wire logic clk,
  input wire logic reset_n,
  ecg_pwm_if.gen   pwm
);
  typedef struct packed {
    ecg_pkg::ecg_pwm_state_t st;  // phase
    logic [15:0]             cnt; // ticks in period
    logic                    out; // registered output
  } ecg_pwm_reg_t;

  ecg_pwm_reg_t cur;
  ecg_pwm_reg_t next_cur;

  assign pwm.out = cur.out;

  // phase walk on each prescaled tick
  always_comb begin
    next_cur = cur;
    case (cur.st)
      ecg_pkg::ECG_PWM_IDLE: begin
        next_cur.cnt = 16'h0000;
        next_cur.out = 1'b0;
        if (pwm.enable) begin
          next_cur.st = ecg_pkg::ECG_PWM_LOW;
        end
      end
      ecg_pkg::ECG_PWM_LOW: begin
        // off time is T*(data+1)
        if (pwm.tick) begin
          next_cur.cnt = cur.cnt + 16'h0001;
          if (cur.cnt == pwm.data) begin
            next_cur.st  = ecg_pkg::ECG_PWM_HIGH;
            next_cur.out = 1'b1;
          end
        end
      end
      ecg_pkg::ECG_PWM_HIGH: begin
        // period ends at T*(compare+1)
        if (pwm.tick) begin
          next_cur.cnt = cur.cnt + 16'h0001;
          if (cur.cnt == pwm.compare) begin
            next_cur.st  = ecg_pkg::ECG_PWM_LOW;
            next_cur.cnt = 16'h0000;
            next_cur.out = 1'b0;
          end
        end
      end
      default: begin
        next_cur.st = ecg_pkg::ECG_PWM_IDLE;
      end
    endcase
    // disable stops the waveform at once
    if (!pwm.enable) begin
      next_cur.st  = ecg_pkg::ECG_PWM_IDLE;
      next_cur.out = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule

// ### ecg_pwm_if.sv
/*
  ecg_pwm_if: settings and output of the pwm gate generator.
  assumes one clock owned by the top module.
*/
`timescale 1ns/1ps
interface ecg_pwm_if;
  logic        enable;    // pwm_gate_enable
  logic        tick;      // prescaled clock period T
  logic [15:0] compare;   // compare value
  logic [15:0] data;      // data value
  logic        out;       // pwm_gate_output
  modport gen (input enable, tick, compare, data, output out);
  modport ctl (output enable, tick, compare, data, input out);
endinterface

// ### ecg_top.sv
/*
  ecg_top: count gating, pwm gate and gate interrupt of the event counter.
  assumes synchronous inputs, one 10 MHz clock and a byte register port.
*/
// How it works
// - gate pin edge sets flag while pwm disabled; enable raises irq
// - edge bits pick rise, fall, both
// - pwm enabled: count only while pwm high
// - pwm disabled: gate pin gates counting
// - one gate acts on both counters
// - pwm gate shares vector six interrupt
// - pwm edge sets same flag, raises irq
// - pwm edge sense from same bits
// - gate cuts counting abruptly, one count slip
// - watch/standby: count, overflow flags untouched
// - low-power modes: only external events count
// - watch/standby: gating works, no pin irq
// - module standby: counters halt, pin ignored
// - synchronised pin irq may skew one cycle
`timescale 1ns/1ps
module ecg_top (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] addr,          // register address
  input  wire logic [7:0] wdata,         // write data
  input  wire logic       wr,            // write strobe
  input  wire logic       rd,            // read strobe
  output logic      [7:0] rdata,         // read data, cycle after rd
  input  wire logic       ext_gate_input,// gate pin level
  input  wire logic       evt_low,       // event pulse, low counter
  input  wire logic       evt_high,      // event pulse, high counter
  output logic            irq,           // level interrupt
  output logic            pwm_gate_output// pwm gate waveform
);
  // all registered state of the top
  typedef struct packed {
    logic [7:0]  edge_sel;     // edge_select_reg
    logic [7:0]  ctrl;         // counter_ctrl_status, writable part
    logic [1:0]  ovf;          // high, low overflow flags
    logic [15:0] compare;      // pwm compare
    logic [15:0] data;         // pwm data
    logic        gate_flag;    // gate_irq_flag
    logic        gate_en;      // gate_irq_enable
    ecg_pkg::ecg_mode_t mode;  // power mode
    logic        pin_q;        // previous gate pin level
    logic        pwm_q;        // previous pwm level
    logic [5:0]  pre;          // prescaler
    logic [7:0]  rdata;        // read data
    logic        irq;          // interrupt output
    logic        pwm_out;      // registered pwm copy
  } ecg_top_reg_t;

  ecg_top_reg_t cur;
  ecg_top_reg_t next_cur;
  ecg_pwm_if    pwm_bus ();

  logic       gate_open;       // counting allowed
  logic       pin_irq_ok;      // pin may raise irq in this mode
  logic       run_mode;        // counters may run in this mode
  logic       ovf_upd;         // overflow flags may change
  logic [7:0] cnt_high;
  logic [7:0] cnt_low;
  logic       wrap_high;
  logic       wrap_low;
  logic       pin_hit;
  logic       pwm_hit;
  logic       low_power;
  logic       lp_deep;
  logic       tick;

  assign rdata           = cur.rdata;
  assign irq             = cur.irq;
  assign pwm_gate_output = cur.pwm_out;

  // pwm generator settings
  assign pwm_bus.enable  = cur.edge_sel[ecg_pkg::PWM_ENABLE_BIT];
  assign pwm_bus.tick    = tick;
  assign pwm_bus.compare = cur.compare;
  assign pwm_bus.data    = cur.data;

  ecg_pwm u_pwm (
    .clk     (clk),
    .reset_n (reset_n),
    .pwm     (pwm_bus.gen)
  );

  ecg_counter u_cnt (
    .clk       (clk),
    .reset_n   (reset_n),
    .inc_low   (evt_low & gate_open & run_mode),
    .inc_high  (evt_high & gate_open & run_mode),
    .mode_8bit (cur.ctrl[ecg_pkg::MODE_8BIT_BIT]),
    .cue_high  (cur.ctrl[ecg_pkg::CUE_HIGH_BIT]),
    .cue_low   (cur.ctrl[ecg_pkg::CUE_LOW_BIT]),
    .crc_high  (cur.ctrl[ecg_pkg::CRC_HIGH_BIT]),
    .cnt_high  (cnt_high),
    .cnt_low   (cnt_low),
    .wrap_high (wrap_high),
    .wrap_low  (wrap_low)
  );

  // mode and gate decode
  always_comb begin
    // prescaled tick: phi/2 << sel, capped at phi/64 for sel 5 and up
    case (cur.edge_sel[ecg_pkg::PWM_CLK_SEL_LSB +: 3])
      3'h0:    tick = cur.pre[0:0] == 1'h1;
      3'h1:    tick = cur.pre[1:0] == 2'h3;
      3'h2:    tick = cur.pre[2:0] == 3'h7;
      3'h3:    tick = cur.pre[3:0] == 4'hF;
      3'h4:    tick = cur.pre[4:0] == 5'h1F;
      default: tick = cur.pre == ecg_pkg::PRESCALE_TOP;
    endcase
    low_power = (cur.mode == ecg_pkg::ECG_WATCH) || (cur.mode == ecg_pkg::ECG_SUBACT)
             || (cur.mode == ecg_pkg::ECG_SUBSLEEP) || (cur.mode == ecg_pkg::ECG_STANDBY);
    lp_deep   = (cur.mode == ecg_pkg::ECG_WATCH) || (cur.mode == ecg_pkg::ECG_STANDBY);
    // only external events count in low power module standby halts
    run_mode   = (cur.mode != ecg_pkg::ECG_MODSTBY) && (!low_power || cur.ctrl[ecg_pkg::ASYNC_SRC_BIT]);
    ovf_upd    = !lp_deep;
    pin_irq_ok = !lp_deep && (cur.mode != ecg_pkg::ECG_MODSTBY);
    // gate selects pwm or pin, common to both counters
    // combinational gate: a pulse in the drop cycle is lost, one count slip
    gate_open = cur.edge_sel[ecg_pkg::PWM_ENABLE_BIT] ? pwm_bus.out : ext_gate_input;
    // edge sense from shared select bits
    pin_hit = ecg_pkg::ecg_edge_hit(cur.pin_q, ext_gate_input, cur.edge_sel[1:0]);
    pwm_hit = ecg_pkg::ecg_edge_hit(cur.pwm_q, pwm_bus.out, cur.edge_sel[1:0]);
  end

  // register file, flags and interrupt
  always_comb begin
    next_cur         = cur;
    next_cur.pin_q   = ext_gate_input;
    next_cur.pwm_q   = pwm_bus.out;
    next_cur.pwm_out = pwm_bus.out;
    next_cur.pre     = cur.pre + 6'h01;
    next_cur.rdata   = ecg_pkg::RESET_BYTE;
    // read data, valid one cycle after strobe
    if (rd) begin
      case (addr)
        ecg_pkg::ADDR_EDGE_SEL:   next_cur.rdata = cur.edge_sel;
        ecg_pkg::ADDR_CTRL_STAT:  next_cur.rdata = {cur.ovf, cur.ctrl[5:0]};
        ecg_pkg::ADDR_CMP_UPPER:  next_cur.rdata = cur.compare[15:8];
        ecg_pkg::ADDR_CMP_LOWER:  next_cur.rdata = cur.compare[7:0];
        ecg_pkg::ADDR_DAT_UPPER:  next_cur.rdata = cur.data[15:8];
        ecg_pkg::ADDR_DAT_LOWER:  next_cur.rdata = cur.data[7:0];
        ecg_pkg::ADDR_IRQ_FLAG:   next_cur.rdata = {7'h00, cur.gate_flag};
        ecg_pkg::ADDR_IRQ_ENABLE: next_cur.rdata = {7'h00, cur.gate_en};
        ecg_pkg::ADDR_CNT_HIGH:   next_cur.rdata = cnt_high;
        ecg_pkg::ADDR_CNT_LOW:    next_cur.rdata = cnt_low;
        ecg_pkg::ADDR_MODE:       next_cur.rdata = {5'h00, cur.mode};
        default:                  next_cur.rdata = ecg_pkg::RESET_BYTE;
      endcase
    end
    // writes; flags clear by writing one
    if (wr) begin
      case (addr)
        ecg_pkg::ADDR_EDGE_SEL:   next_cur.edge_sel = {1'b0, wdata[6:0]};
        ecg_pkg::ADDR_CTRL_STAT: begin
          next_cur.ctrl = {2'b00, wdata[5:0]};
          if (wdata[ecg_pkg::OVF_HIGH_BIT]) begin
            next_cur.ovf[1] = 1'b0;
          end
          if (wdata[ecg_pkg::OVF_LOW_BIT]) begin
            next_cur.ovf[0] = 1'b0;
          end
        end
        // halting pwm first is software's duty; writes still land
        ecg_pkg::ADDR_CMP_UPPER:  next_cur.compare[15:8] = wdata;
        ecg_pkg::ADDR_CMP_LOWER:  next_cur.compare[7:0]  = wdata;
        ecg_pkg::ADDR_DAT_UPPER:  next_cur.data[15:8]    = wdata;
        ecg_pkg::ADDR_DAT_LOWER:  next_cur.data[7:0]     = wdata;
        ecg_pkg::ADDR_IRQ_FLAG: begin
          if (wdata[ecg_pkg::GATE_IRQ_BIT]) begin
            next_cur.gate_flag = 1'b0;
          end
        end
        ecg_pkg::ADDR_IRQ_ENABLE: next_cur.gate_en = wdata[ecg_pkg::GATE_IRQ_BIT];
        ecg_pkg::ADDR_MODE: begin
          next_cur.mode = ecg_pkg::ecg_mode_t'(wdata[2:0]);
        end
        default: begin
          // unmapped: ignored
        end
      endcase
    end
    // overflow flags; set wins over clear
    if (ovf_upd && wrap_high) begin
      next_cur.ovf[1] = 1'b1;
    end
    if (ovf_upd && wrap_low) begin
      next_cur.ovf[0] = 1'b1;
    end
    // pin edge, registered one cycle: skew vs gate
    if (pin_hit && pin_irq_ok && !cur.edge_sel[ecg_pkg::PWM_ENABLE_BIT]) begin
      next_cur.gate_flag = 1'b1;
    end
    // pwm edge shares flag and vector
    if (pwm_hit && cur.edge_sel[ecg_pkg::PWM_ENABLE_BIT]) begin
      next_cur.gate_flag = 1'b1;
    end
    // level irq while flag and enable both set
    next_cur.irq = next_cur.gate_flag & next_cur.gate_en;
  end

  // single state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule

// ### ecg_top_monitor.sv
/*
  ecg_top_monitor: port assertions and covers for ecg_top.
  assumes one clock and a master keeping the strobe rules.
*/
`timescale 1ns/1ps
module ecg_top_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       ext_gate_input,
  input wire logic       evt_low,
  input wire logic       evt_high,
  input wire logic       irq,
  input wire logic       pwm_gate_output
);
  logic [7:0] sh [0:15];  // shadow of every written byte
  logic [2:0] md;         // power mode shadow
  logic       pin_ok;     // pin edges may raise irq
  logic       clr;        // flag clear write
  logic       p_q;        // last pwm output
  logic       ok;         // current run began at a seen change
  int         run;        // cycles in current run
  int         tk;         // prescale period in clocks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  assign md     = sh[10][2:0];
  assign pin_ok = !sh[0][2] && sh[7][0] && !(md inside {3'h2, 3'h5, 3'h6});
  assign clr    = wr && addr == ecg_pkg::ADDR_IRQ_FLAG && wdata[0];
  assign tk     = (sh[0][6:4] >= 3'h5) ? 64 : (2 << sh[0][6:4]);
  // edge decode, kept apart from the design's own
  function automatic logic edg(input logic p, input logic c, input logic [1:0] s);
    edg = s[1] ? (p ^ c) : (s[0] ? (p & ~c) : (~p & c));
  endfunction
  // shadows follow writes; unmapped bytes are never looked at
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) sh[i] <= 8'h00;
    end else if (wr) begin
      sh[addr] <= wdata;
    end
  end
  // run lengths; the first run after enable is skipped since its phase is free
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p_q <= 1'b0;
      ok  <= 1'b0;
      run <= 0;
    end else begin
      p_q <= pwm_gate_output;
      run <= (pwm_gate_output != p_q) ? 1 : run + 1;
      ok  <= sh[0][2] && (ok || pwm_gate_output != p_q);
    end
  end
  a_pin_edge_irq: assert property (pin_ok && edg($past(ext_gate_input), ext_gate_input, sh[0][1:0]) |-> ##[1:2] irq)
    else $error("pin edge gave no interrupt");
  a_pwm_edge_irq: assert property (sh[0][2] && sh[7][0] && sh[0] == $past(sh[0], 3) && md == 3'h0
    && edg($past(pwm_gate_output), pwm_gate_output, sh[0][1:0]) |-> ##[0:2] irq)
    else $error("pwm edge gave no interrupt");
  a_irq_masked: assert property (!sh[7][0] && !$past(sh[7][0]) |-> !irq)
    else $error("interrupt while disabled");
  a_irq_sticky: assert property ($past(irq) && sh[7][0] && $past(sh[7][0]) && !$past(clr) |-> irq)
    else $error("interrupt dropped without clear");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_rd: assert property ($past(rd) && $past(addr) > 4'hA |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pwm_off_low: assert property (!sh[0][2] && !$past(sh[0][2]) && !$past(sh[0][2], 2) |-> !pwm_gate_output)
    else $error("pwm output high while disabled");
  a_pwm_low_len: assert property (pwm_gate_output && !p_q && ok |-> run == tk * (sh[5] + 256 * sh[4] + 1))
    else $error("pwm low time wrong");
  a_pwm_high_len: assert property (!pwm_gate_output && p_q && ok
    |-> run == tk * ((sh[3] + 256 * sh[2]) - (sh[5] + 256 * sh[4])))
    else $error("pwm high time wrong");
  c_irq: cover property ($rose(irq));
  c_pwm: cover property ($rose(pwm_gate_output) && ok);
  c_unmapped: cover property (rd && addr > 4'hA);
endmodule
bind ecg_top ecg_top_chk ecg_top_chk_i (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .ext_gate_input,
  .evt_low, .evt_high, .irq, .pwm_gate_output);

// ### tb.sv
/*
  tb: self-checking bench for ecg_top.
  assumes package, interface, design, monitor and model compile first.
*/
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [1:0] sel;  // edge choice
    logic       lvl;  // final pin level
    logic       exp;  // flag expected
  } ecg_row_t;
  // every sense choice in both directions, except sel 3 falling only
  localparam ecg_row_t ROWS [0:6] = '{4'h3, 4'h0, 4'h6, 4'h5, 4'hB, 4'h9, 4'hD};
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [3:0] addr;     // bus address, driven from the main sequence
  logic [7:0] wdata;    // bus write data
  logic       wr;       // write strobe
  logic       rd;       // read strobe
  logic       evt_low;  // event pulse, low counter
  logic       evt_high; // event pulse, high counter
  logic [7:0] rdata;
  logic       irq;
  logic       pwm_gate_output;
  logic       ext_gate_input;
  logic [7:0] d;        // last read value
  int         errors = 0;
  int         n_tests = 0;
  int         k;        // loop and span count
  always #50 clk = ~clk;
  ecg_top ecg_top_i (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .ext_gate_input,
    .evt_low, .evt_high, .irq, .pwm_gate_output);
  ecg_gate_model ecg_gate_model_i (.clk, .irq, .ext_gate_input);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // set control, then n events on both counters
  task automatic run(input logic [7:0] ctl, input int n);
    wr_reg(ecg_pkg::ADDR_CTRL_STAT, ctl);
    @(posedge clk);
    evt_low  <= 1'b1;
    evt_high <= 1'b1;
    repeat (n) @(posedge clk);
    evt_low  <= 1'b0;
    evt_high <= 1'b0;
  endtask
  // counting stopped before reading, else the value may tear
  task automatic cnt_is(input logic [7:0] lo, input logic [7:0] hi);
    wr_reg(ecg_pkg::ADDR_CTRL_STAT, 8'h1C);
    rd_reg(ecg_pkg::ADDR_CNT_LOW, d);
    chk(d, lo);
    rd_reg(ecg_pkg::ADDR_CNT_HIGH, d);
    chk(d, hi);
  endtask
  // cycles the pwm output keeps one level, bounded
  task automatic span(input logic lvl);
    k = 0;
    while (pwm_gate_output === lvl && k < 200) begin
      @(negedge clk);
      k++;
    end
  endtask
  // watchdog well past the expected thousand-odd cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end
  initial begin
    // bus and events idle while reset is held
    addr     <= 4'h0;
    wdata    <= 8'h00;
    wr       <= 1'b0;
    rd       <= 1'b0;
    evt_low  <= 1'b0;
    evt_high <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    // reset values, 0xB unmapped
    for (k = 0; k < 12; k++) begin
      rd_reg(k[3:0], d);
      chk(d, ecg_pkg::RESET_BYTE);
    end
    $display("test reset done");
    wr_reg(ecg_pkg::ADDR_IRQ_ENABLE, 8'h01);
    for (k = 0; k < 7; k++) begin
      wr_reg(ecg_pkg::ADDR_EDGE_SEL, {6'h00, ROWS[k].sel});
      ecg_gate_model_i.drive(~ROWS[k].lvl);
      repeat (3) @(negedge clk);
      wr_reg(ecg_pkg::ADDR_IRQ_FLAG, 8'h01);
      ecg_gate_model_i.drive(ROWS[k].lvl);
      repeat (3) @(negedge clk);
      chk({7'h00, irq}, {7'h00, ROWS[k].exp});
      rd_reg(ecg_pkg::ADDR_IRQ_FLAG, d);
      chk(d & 8'h01, {7'h00, ROWS[k].exp});
    end
    // masked edge: flag kept, irq follows enable, clear drops it
    wr_reg(ecg_pkg::ADDR_IRQ_ENABLE, 8'h00);
    ecg_gate_model_i.drive(1'b1);
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    wr_reg(ecg_pkg::ADDR_IRQ_ENABLE, 8'h01);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    wr_reg(ecg_pkg::ADDR_IRQ_FLAG, 8'h01);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    $display("test edges done");
    // high enable and release set together before any event
    ecg_gate_model_i.drive(1'b0);
    run(8'h1F, 5);
    cnt_is(8'h00, 8'h00);
    ecg_gate_model_i.drive(1'b1);
    run(8'h1F, 5);
    cnt_is(8'h05, 8'h05);
    wr_reg(ecg_pkg::ADDR_MODE, {5'h00, ecg_pkg::ECG_MODSTBY});
    run(8'h1F, 3);
    cnt_is(8'h05, 8'h05);
    wr_reg(ecg_pkg::ADDR_MODE, {5'h00, ecg_pkg::ECG_SUBACT});
    run(8'h0F, 3);
    cnt_is(8'h05, 8'h05);
    run(8'h1F, 3);
    cnt_is(8'h08, 8'h08);
    $display("test gating done");
    // watch: gating holds, no pin irq, wrap leaves overflow flags
    wr_reg(ecg_pkg::ADDR_MODE, {5'h00, ecg_pkg::ECG_WATCH});
    wr_reg(ecg_pkg::ADDR_IRQ_FLAG, 8'h01);
    ecg_gate_model_i.drive(1'b0);
    run(8'h1F, 4);
    chk({7'h00, irq}, 8'h00);
    cnt_is(8'h08, 8'h08);
    ecg_gate_model_i.drive(1'b1);
    run(8'h1F, 256);
    cnt_is(8'h08, 8'h08);
    rd_reg(ecg_pkg::ADDR_CTRL_STAT, d);
    chk(d & 8'hC0, 8'h00);
    wr_reg(ecg_pkg::ADDR_MODE, {5'h00, ecg_pkg::ECG_ACTIVE});
    run(8'h1F, 256);
    rd_reg(ecg_pkg::ADDR_CTRL_STAT, d);
    chk(d & 8'hC0, 8'hC0);
    // 16-bit: low wraps 08+F8 to 00 and carries once into high
    run(8'h17, 248);
    cnt_is(8'h00, 8'h09);
    $display("test modes done");
    // pwm set up only while halted, data below compare: T 2, low 4, high 4
    wr_reg(ecg_pkg::ADDR_CMP_UPPER, 8'h00);
    wr_reg(ecg_pkg::ADDR_CMP_LOWER, 8'h03);
    wr_reg(ecg_pkg::ADDR_DAT_UPPER, 8'h00);
    wr_reg(ecg_pkg::ADDR_DAT_LOWER, 8'h01);
    ecg_gate_model_i.drive(1'b0);
    wr_reg(ecg_pkg::ADDR_EDGE_SEL, 8'h04);
    span(1'b0);
    span(1'b1);
    span(1'b0);
    chk(k[7:0], 8'h04);
    span(1'b1);
    chk(k[7:0], 8'h04);
    // two full periods of events with the pin closed: half pass, one slip allowed
    run(8'h1F, 16);
    wr_reg(ecg_pkg::ADDR_CTRL_STAT, 8'h1C);
    rd_reg(ecg_pkg::ADDR_CNT_LOW, d);
    chk({7'h00, d >= 8'h07 && d <= 8'h09}, 8'h01);
    for (k = 0; k < 3; k++) begin
      wr_reg(ecg_pkg::ADDR_EDGE_SEL, 8'h04 | k[7:0]);
      wr_reg(ecg_pkg::ADDR_IRQ_FLAG, 8'h01);
      repeat (12) @(negedge clk);
      rd_reg(ecg_pkg::ADDR_IRQ_FLAG, d);
      chk(d & 8'h01, 8'h01);
    end
    wr_reg(ecg_pkg::ADDR_EDGE_SEL, 8'h00);
    chk({7'h00, ecg_gate_model_i.irq_rises > 0}, 8'h01);
    $display("test pwm done");
    end_sim();
  end
endmodule
